// ==== bench/adc_checker.sv ====
`timescale 1ns/1ps
module adc_chk #(
  parameter int CONV_DIV = 1
) (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       chip_select_n,
  input wire logic       start_n,
  input wire logic       read_n,
  input wire logic [9:0] trial_code,
  input wire logic [7:0] data_oe,
  input wire logic       conversion_done_n
);
  localparam int T_LO = 78 * CONV_DIV;
  localparam int T_HI = 82 * CONV_DIV + 6;
  int cnt;
  int next_cnt;
  always_comb next_cnt = conversion_done_n ? 0 : cnt + 1;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
    end else begin
      cnt <= next_cnt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_go; (!chip_select_n && !start_n) ##1 (start_n && chip_select_n); endsequence
  property p_hold;
    (!chip_select_n && !start_n) [*2] |=> (conversion_done_n && trial_code == 10'h000);
  endproperty
  property p_clr; s_go |-> conversion_done_n [*8]; endproperty
  property p_msb; s_go |-> ##[0:3] trial_code == 10'h200; endproperty
  property p_time; s_go |-> ##[T_LO:T_HI] $fell(conversion_done_n); endproperty
  property p_pulse; $rose(conversion_done_n) |-> cnt >= sar_adc_pkg::DONE_PULSE_CYCLES; endproperty
  property p_rd; (!chip_select_n && !read_n && cnt > 45) |-> ##[1:3] conversion_done_n; endproperty
  property p_on; (!chip_select_n && !read_n) |=> data_oe == 8'hff; endproperty
  property p_off; (chip_select_n || read_n) |=> data_oe == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("done fell in hold");
  a_clr: assert property (p_clr) else $error("done low after start");
  a_msb: assert property (p_msb) else $error("no msb trial");
  a_time: assert property (p_time) else $error("bad conv time");
  a_pulse: assert property (p_pulse) else $error("short done pulse");
  a_rd: assert property (p_rd) else $error("read kept done");
  a_on: assert property (p_on) else $error("bus not driven");
  a_off: assert property (p_off) else $error("bus not released");
endmodule : adc_chk

// ==== bench/adc_host_model.sv ====
`timescale 1ns/1ps
module adc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  output logic            chip_select_n = 1'b1,
  output logic            start_n = 1'b1,
  output logic            read_n = 1'b1
);
  logic [7:0] bus;
  // Released bus shows garbage, not the old byte
  assign bus = (data_oe == 8'hff) ? data_out : ~data_out;
  task automatic start_conv;
    @(negedge core_clk);
    chip_select_n = 1'b0;
    start_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chip_select_n = 1'b1;
    start_n = 1'b1;
  endtask : start_conv
  task automatic read_byte(output logic [7:0] b);
    @(negedge core_clk);
    chip_select_n = 1'b0;
    read_n = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    b = bus;
    chip_select_n = 1'b1;
    read_n = 1'b1;
  endtask : read_byte
endmodule : adc_host_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       neg_ge = 1'b0;
  logic [9:0] level = 10'h000;
  logic [9:0] trial_code;
  logic [7:0] data_out;
  logic [7:0] data_oe;
  logic       cs_n;
  logic       start_n;
  logic       read_n;
  logic       done_n;
  int         n_fail = 0;
  int         tests_run = 0;
  always #5 core_clk = ~core_clk;
  sar_adc_host_interface #(.CONV_DIV(1)) sar_adc_host_interface_inst (.core_clk(core_clk),
    .arst_n(arst_n), .chip_select_n(cs_n), .start_n(start_n), .read_n(read_n),
    .compare_high(trial_code <= level), .negative_ge_positive(neg_ge),
    .trial_code(trial_code), .data_out(data_out), .data_oe(data_oe), .conversion_done_n(done_n));
  adc_host_model adc_host_model_inst (.core_clk(core_clk), .data_out(data_out),
    .data_oe(data_oe), .chip_select_n(cs_n), .start_n(start_n), .read_n(read_n));
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Reads start right at done, while the pulse still holds it low
  task automatic t_conv(input logic [9:0] lvl, input logic neg, input logic [9:0] exp);
    logic [7:0] b;
    @(negedge core_clk);
    level = lvl;
    neg_ge = neg;
    adc_host_model_inst.start_conv();
    for (int i = 0; i < 200 && done_n !== 1'b0; i++) @(negedge core_clk);
    check("done", {9'h000, done_n}, 10'h000);
    adc_host_model_inst.read_byte(b);
    check("byte1", {2'h0, b}, {2'h0, exp[9:2]});
    adc_host_model_inst.read_byte(b);
    check("byte2", {2'h0, b}, {2'h0, exp[1:0], 6'h00});
    check("pulse", {9'h000, done_n}, 10'h000);
    repeat (50) @(posedge core_clk);
    adc_host_model_inst.read_byte(b);
    check("wrap", {2'h0, b}, {2'h0, exp[9:2]});
    check("clear", {9'h000, done_n}, 10'h001);
    $display("test %h end", lvl);
  endtask : t_conv
  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    t_conv(10'h2b5, 1'b0, 10'h2b5);
    t_conv(10'h3ff, 1'b0, 10'h3ff);
    t_conv(10'h3ff, 1'b1, 10'h000);
    final_report();
  end
  // Three conversions take about 440 cycles
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
endmodule : tb
bind sar_adc_host_interface adc_chk #(.CONV_DIV(CONV_DIV)) adc_chk_inst (.core_clk(core_clk),
  .arst_n(arst_n), .chip_select_n(chip_select_n), .start_n(start_n), .read_n(read_n),
  .trial_code(trial_code), .data_oe(data_oe), .conversion_done_n(conversion_done_n));

// ==== logic/conv_tick.sv ====
`timescale 1ns/1ps
module conv_tick #(
  parameter int DIV = 50
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic clear,
  output logic      tick
);
  logic [$clog2(DIV+1)-1:0] count;
  logic [$clog2(DIV+1)-1:0] next_count;
  logic                     next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_count = count + 1'b1;
    if (clear) begin
      next_count = '0;
    end else if (count == ($clog2(DIV+1))'(DIV - 1)) begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule : conv_tick

// ==== logic/sar_adc_host_interface.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Search starts at MSB, one bit per step
// - Ten comparisons in 80 clocks, then latch
// - Negative input at or above positive gives zero
// - Byte one bits 9..2, byte two 1..0 then zeros
// - Chip select and start low set start latch
// - Start clears sequencer, done flag, loads one
// - Drive bus during read, release after read
// - Hold reset while both low, start after release
// - Done output low at least 400 ns on transfer; a start from idle clears it at once
// - Select plus read clears done, enables latch
module sar_adc_host_interface #(
  parameter int CONV_DIV = sar_adc_pkg::CONV_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        chip_select_n,
  input  wire logic        start_n,
  input  wire logic        read_n,
  input  wire logic        compare_high,
  input  wire logic        negative_ge_positive,
  output logic [9:0]       trial_code,
  output logic [7:0]       data_out,
  output logic [7:0]       data_oe,
  output logic             conversion_done_n
);
  localparam int RB = sar_adc_pkg::RESULT_BITS;
  localparam int BB = sar_adc_pkg::BUS_BITS;
  localparam int CPB = sar_adc_pkg::CYCLES_PER_BIT;
  localparam int DPC = sar_adc_pkg::DONE_PULSE_CYCLES;

  // Code 2'b11 is never used and falls back to idle
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    HOLD  = 2'b01,
    RUN   = 2'b10
  } conv_state_e;

  conv_state_e   state;
  conv_state_e   next_state;
  logic [RB-1:0] approximation_register;
  logic [RB-1:0] next_approximation_register;
  logic [RB-1:0] sequencer;
  logic [RB-1:0] next_sequencer;
  logic [RB-1:0] out_latch;
  logic [RB-1:0] next_out_latch;
  logic [2:0]    sub_count;
  logic [2:0]    next_sub_count;
  logic [5:0]    pulse_count;
  logic [5:0]    next_pulse_count;
  logic          done_flag;
  logic          next_done_flag;
  logic          second_byte;
  logic          next_second_byte;
  logic          read_active;
  logic          next_read_active;
  logic [BB-1:0] next_data_out;
  logic [BB-1:0] next_data_oe;
  logic [RB-1:0] next_trial_code;
  logic          tick;
  logic          start_req;
  logic          read_req;
  logic          step_end;
  logic          last_step;
  logic          read_release;
  logic          next_conversion_done_n;

  assign start_req = !chip_select_n && !start_n;
  assign read_req  = !chip_select_n && !read_n;
  // Compare result is taken on the last tick of a bit period
  assign step_end = tick && (sub_count == 3'(CPB - 1));
  assign last_step = step_end && sequencer[0];
  // Pointer moves on release so a held read keeps its byte
  assign read_release = read_active && !read_req;

  // Divider idles outside a search so every search starts aligned
  conv_tick #(
    .DIV (CONV_DIV)
  ) u_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (state != RUN),
    .tick     (tick)
  );

  // Search sequencing, result transfer and end flag
  always_comb begin
    next_state = state;
    next_approximation_register = approximation_register;
    next_sequencer = sequencer;
    next_out_latch = out_latch;
    next_sub_count = sub_count;
    next_pulse_count = (pulse_count != 6'h00) ? pulse_count - 6'h01 : 6'h00;
    next_done_flag = done_flag;
    unique case (state)
      IDLE: begin
        if (start_req) begin
          next_state = HOLD;
        end
      end
      HOLD: begin
        next_sequencer = '0;
        next_approximation_register = '0;
        next_done_flag = 1'b0;
        next_sub_count = '0;
        // Wide strobes keep the search parked here
        if (!start_req) begin
          next_state = RUN;
          next_sequencer = {1'b1, {(RB-1){1'b0}}};
          next_approximation_register = {1'b1, {(RB-1){1'b0}}};
        end
      end
      RUN: begin
        if (start_req) begin
          // A new start throws the running search away
          next_state = HOLD;
        end else if (step_end) begin
          next_sub_count = '0;
          if (!compare_high) begin
            next_approximation_register = approximation_register & ~sequencer;
          end
          next_approximation_register = next_approximation_register
                                        | (sequencer >> 1);
          next_sequencer = sequencer >> 1;
          if (last_step) begin
            next_state = IDLE;
            next_out_latch = negative_ge_positive ? '0 :
                             (next_approximation_register & ~(sequencer >> 1));
            next_done_flag = 1'b1;
            next_pulse_count = 6'(DPC);
          end
        end else if (tick) begin
          next_sub_count = sub_count + 3'h1;
        end
      end
      default: next_state = IDLE;
    endcase
    // A start from idle drops an unread result
    if (state != HOLD && state != RUN && start_req) begin
      next_done_flag = 1'b0;
    end
    // Read clear waits out the minimum pulse, set wins
    if (read_req && next_pulse_count == 6'h00) begin
      next_done_flag = 1'b0;
    end
  end

  // Byte pointer and bus drive
  always_comb begin
    next_read_active = read_req;
    next_second_byte = second_byte;
    if (read_release) begin
      next_second_byte = !second_byte;
    end
    if (state == HOLD) begin
      next_second_byte = 1'b0;
    end
    if (read_req) begin
      next_data_oe = {BB{1'b1}};
    end else begin
      next_data_oe = {BB{1'b0}};
    end
    if (next_second_byte) begin
      next_data_out = {out_latch[1:0], {sar_adc_pkg::SECOND_PAD{1'b0}}};
    end else begin
      next_data_out = out_latch[sar_adc_pkg::FIRST_HI:sar_adc_pkg::FIRST_LO];
    end
  end

  // Outputs leave flops one edge after their next values
  always_comb begin
    next_trial_code = next_approximation_register;
    next_conversion_done_n = !next_done_flag;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IDLE;
      approximation_register <= sar_adc_pkg::RESULT_RESET;
      sequencer <= '0;
      out_latch <= sar_adc_pkg::RESULT_RESET;
      sub_count <= '0;
      pulse_count <= '0;
      done_flag <= 1'b0;
    end else begin
      state <= next_state;
      approximation_register <= next_approximation_register;
      sequencer <= next_sequencer;
      out_latch <= next_out_latch;
      sub_count <= next_sub_count;
      pulse_count <= next_pulse_count;
      done_flag <= next_done_flag;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      second_byte <= 1'b0;
      read_active <= 1'b0;
      data_out <= '0;
      data_oe <= '0;
    end else begin
      second_byte <= next_second_byte;
      read_active <= next_read_active;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trial_code <= '0;
      conversion_done_n <= 1'b1;
    end else begin
      trial_code <= next_trial_code;
      conversion_done_n <= next_conversion_done_n;
    end
  end
endmodule : sar_adc_host_interface

// ==== logic/sar_adc_pkg.sv ====
package sar_adc_pkg;
  localparam int RESULT_BITS = 10;
  localparam int BUS_BITS = 8;
  localparam int CLK_MHZ = 100;
  localparam int CONV_CYCLES = 80;
  localparam int CYCLES_PER_BIT = CONV_CYCLES / RESULT_BITS;
  localparam int CONV_DIV = 50;
  localparam int DONE_PULSE_NS = 400;
  localparam int DONE_PULSE_CYCLES = (DONE_PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;
  localparam int FIRST_HI = 9;
  localparam int FIRST_LO = 2;
  localparam int SECOND_PAD = 6;
endpackage : sar_adc_pkg
